// [core/led_fn_pkg.sv]
package led_fn_pkg;

    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [3:0] ADDR_LED_FN = 4'h0;
    localparam logic [3:0] ADDR_MISC = 4'h4;

    // ==========================================================
    // LED function enable register fields
    localparam int BIT_STATE = 15;
    localparam int BIT_MAGIC = 9;
    localparam int BIT_FD_LINK = 8;
    localparam int BIT_STRETCH = 7;
    localparam int BIT_RSVD6 = 6;
    localparam int BIT_RX_MATCH = 5;
    localparam int BIT_TX = 4;
    localparam int BIT_RX_POL = 3;
    localparam int BIT_RX = 2;
    localparam int BIT_JABBER = 1;
    localparam int BIT_COLL = 0;
    // Writable bits: 9..7 and 5..0; bit 15 read-only, 14..10 and 6 reserved
    localparam logic [15:0] LED_FN_WMASK = 16'h03BF;
    localparam logic [15:0] LED_FN_RESET = 16'h0090;

    // ==========================================================
    // Miscellaneous configuration two register fields
    localparam int BIT_FD_ENABLE = 0;
    localparam int BIT_ATTACH_FD = 1;
    localparam logic [1:0] MISC_RESET = 2'h0;

    // ==========================================================
    // Active network port
    typedef enum logic [1:0] {
        PORT_TP = 2'h0,
        PORT_AUI = 2'h1,
        PORT_GPSI = 2'h2
    } port_sel_t;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 250;
    localparam int STRETCH_US = 50;
    localparam int STRETCH_CYCLES_DEF = STRETCH_US * CLK_MHZ;
    localparam int STRETCH_CNT_W = 24;

endpackage : led_fn_pkg

// [core/led_function_select.sv]
`timescale 1ns/1ps

module led_function_select #(
    parameter int STRETCH_CYCLES = led_fn_pkg::STRETCH_CYCLES_DEF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Avalon-MM slave
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Network events from the controller core
    input wire led_fn_pkg::port_sel_t i_port_sel,
    input wire logic i_link_pass,
    input wire logic i_tx_act,
    input wire logic i_rx_act,
    input wire logic i_rx_addr_match,
    input wire logic i_rx_pol_good,
    input wire logic i_jabber,
    input wire logic i_collision,
    input wire logic i_magic_pkt,
    // Duplex configuration to the core
    output logic o_full_duplex_enable,
    output logic o_attach_port_fd_enable,
    // LED pin, low lights the LED
    output logic o_led_n
);
    import led_fn_pkg::*;

    // ==========================================================
    // State
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_t;

    typedef struct packed {
        bus_state_t bus;
        logic waitreq;
        logic [31:0] rdata;
        logic [15:0] led_fn;
        logic fd_en;
        logic attach_fd;
        logic [STRETCH_CNT_W-1:0] cnt;
        logic led;
    } state_t;

    state_t st_q;
    state_t st_d;

    localparam logic [STRETCH_CNT_W-1:0] STRETCH_LOAD = STRETCH_CNT_W'(STRETCH_CYCLES);

    // ==========================================================
    // Function combining
    logic fd_status;
    logic rx_fn;
    logic raw_fn;
    logic req;

    always_comb begin
        unique case (i_port_sel)
            PORT_TP: fd_status = i_link_pass && st_q.fd_en;
            PORT_AUI: fd_status = st_q.fd_en && st_q.attach_fd;
            PORT_GPSI: fd_status = st_q.fd_en;
            default: fd_status = 1'b0;
        endcase
    end

    assign rx_fn = i_rx_act && (!st_q.led_fn[BIT_RX_MATCH] || i_rx_addr_match);

    assign raw_fn =
        (st_q.led_fn[BIT_FD_LINK] && fd_status) ||
        (st_q.led_fn[BIT_TX] && i_tx_act) ||
        (st_q.led_fn[BIT_RX_POL] && i_rx_pol_good && i_port_sel == PORT_TP) ||
        (st_q.led_fn[BIT_RX] && rx_fn) ||
        (st_q.led_fn[BIT_JABBER] && i_jabber) ||
        (st_q.led_fn[BIT_COLL] && i_collision) ||
        (st_q.led_fn[BIT_MAGIC] && i_magic_pkt);

    assign req = i_read || i_write;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Bus: every request seen in BUS_IDLE is answered in the next cycle
        unique case (st_q.bus)
            BUS_IDLE: begin
                if (req) begin
                    st_d.bus = BUS_ACK;
                    st_d.waitreq = 1'b0;
                    st_d.rdata = 32'h0000_0000;
                    if (i_read && i_address == ADDR_LED_FN) begin
                        st_d.rdata[15:0] = st_q.led_fn;
                        st_d.rdata[BIT_STATE] = raw_fn;
                    end else if (i_read && i_address == ADDR_MISC) begin
                        st_d.rdata[BIT_FD_ENABLE] = st_q.fd_en;
                        st_d.rdata[BIT_ATTACH_FD] = st_q.attach_fd;
                    end
                end
            end
            BUS_ACK: begin
                st_d.bus = BUS_IDLE;
                st_d.waitreq = 1'b1;
                if (i_write && i_address == ADDR_LED_FN) begin
                    if (i_byteenable[0]) begin
                        st_d.led_fn[7:0] = i_writedata[7:0] & LED_FN_WMASK[7:0];
                    end
                    if (i_byteenable[1]) begin
                        st_d.led_fn[15:8] = i_writedata[15:8] & LED_FN_WMASK[15:8];
                    end
                end else if (i_write && i_address == ADDR_MISC && i_byteenable[0]) begin
                    st_d.fd_en = i_writedata[BIT_FD_ENABLE];
                    st_d.attach_fd = i_writedata[BIT_ATTACH_FD];
                end
            end
        endcase

        // Stretcher: restarts on every active cycle, then counts down
        if (st_q.led_fn[BIT_STRETCH]) begin
            if (raw_fn) begin
                st_d.cnt = STRETCH_LOAD;
            end else if (st_q.cnt != '0) begin
                st_d.cnt = st_q.cnt - 1'b1;
            end
            st_d.led = raw_fn || st_q.cnt != '0;
        end else begin
            st_d.cnt = '0;
            st_d.led = raw_fn;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q.bus <= BUS_IDLE;
            st_q.waitreq <= 1'b1;
            st_q.rdata <= 32'h0000_0000;
            st_q.led_fn <= LED_FN_RESET;
            st_q.fd_en <= MISC_RESET[BIT_FD_ENABLE];
            st_q.attach_fd <= MISC_RESET[BIT_ATTACH_FD];
            st_q.cnt <= '0;
            st_q.led <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_waitrequest = st_q.waitreq;
    assign o_readdata = st_q.rdata;
    assign o_full_duplex_enable = st_q.fd_en;
    assign o_attach_port_fd_enable = st_q.attach_fd;
    assign o_led_n = !st_q.led;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_bus_answer: assert property (
        (req && st_q.bus == BUS_IDLE) |=> !o_waitrequest ##1 o_waitrequest)
        else $error("bus answer not one cycle after request");

    a_status_read: assert property (
        (i_read && st_q.bus == BUS_IDLE && i_address == ADDR_LED_FN)
        |=> o_readdata[BIT_STATE] == $past(raw_fn))
        else $error("status bit does not show unstretched function");

    a_reserved_zero: assert property (
        st_q.led_fn[BIT_RSVD6] == 1'b0 && st_q.led_fn[14:10] == 5'h00)
        else $error("reserved bit holds a one");

    a_write_lands: assert property (
        (i_write && st_q.bus == BUS_ACK && i_address == ADDR_LED_FN && i_byteenable[0])
        |=> st_q.led_fn[BIT_STRETCH] == $past(i_writedata[BIT_STRETCH]))
        else $error("stretch enable write lost");

    a_no_stretch: assert property (
        (!st_q.led_fn[BIT_STRETCH]) |=> o_led_n == !$past(raw_fn))
        else $error("led does not follow function without stretch");

    a_stretch_load: assert property (
        (st_q.led_fn[BIT_STRETCH] && raw_fn) |=> st_q.cnt == STRETCH_LOAD && !o_led_n)
        else $error("stretcher not restarted by event");

    a_stretch_hold: assert property (
        (st_q.led_fn[BIT_STRETCH] && st_q.cnt != '0) |=> !o_led_n)
        else $error("led dark while stretching");

    a_fd_twisted: assert property (
        (st_q.led_fn[BIT_FD_LINK] && i_port_sel == PORT_TP && i_link_pass && st_q.fd_en)
        |-> raw_fn)
        else $error("twisted-pair duplex link not shown");

    a_fd_attach_off: assert property (
        (st_q.led_fn[9:0] == 10'h100 && i_port_sel == PORT_AUI && !st_q.attach_fd) |-> !raw_fn)
        else $error("attach port duplex shown without its enable");

    a_fd_serial: assert property (
        (st_q.led_fn[BIT_FD_LINK] && i_port_sel == PORT_GPSI && st_q.fd_en) |-> raw_fn)
        else $error("serial port duplex not shown");

    a_rx_filter: assert property (
        (st_q.led_fn[9:0] == 10'h024 && !i_rx_addr_match) |-> !raw_fn)
        else $error("unmatched receive lit the led");

    a_tx_masked: assert property (
        (st_q.led_fn[9:0] == 10'h000) |-> !raw_fn)
        else $error("function active with nothing enabled");

    a_or_tx: assert property (
        (st_q.led_fn[BIT_TX] && i_tx_act) |-> raw_fn)
        else $error("enabled transmit not in combined function");

    a_jab_coll: assert property (
        ((st_q.led_fn[BIT_JABBER] && i_jabber) || (st_q.led_fn[BIT_COLL] && i_collision))
        |-> raw_fn)
        else $error("jabber or collision missing");

    a_wait_idle: assert property (
        (st_q.bus == BUS_IDLE) |-> o_waitrequest)
        else $error("waitrequest low while idle");

    a_wait_answer: assert property (
        (st_q.bus == BUS_ACK) |-> !o_waitrequest)
        else $error("waitrequest high in answer cycle");

    a_state_ro: assert property (
        (i_write && st_q.bus == BUS_ACK && i_address == ADDR_LED_FN)
        |=> !st_q.led_fn[BIT_STATE])
        else $error("read-only status bit was written");

    a_fd_link_on: assert property (
        (st_q.led_fn[BIT_FD_LINK] && fd_status) |-> raw_fn)
        else $error("duplex link status not passed on");

    a_fd_link_off: assert property (
        (st_q.led_fn[9:0] == 10'h100 && !fd_status) |-> !raw_fn)
        else $error("duplex link shown without status");

    a_fd_no_port: assert property (
        (i_port_sel != PORT_TP && i_port_sel != PORT_AUI && i_port_sel != PORT_GPSI)
        |-> !fd_status)
        else $error("duplex status with no port active");

    a_fd_tp_down: assert property (
        (i_port_sel == PORT_TP && !i_link_pass) |-> !fd_status)
        else $error("twisted-pair duplex status without link pass");

    a_fd_attach_on: assert property (
        (i_port_sel == PORT_AUI && st_q.fd_en && st_q.attach_fd) |-> fd_status)
        else $error("attach port duplex status missing");

    a_fd_serial_off: assert property (
        (i_port_sel == PORT_GPSI && !st_q.fd_en) |-> !fd_status)
        else $error("serial port duplex status without enable");

    a_pol_only: assert property (
        (st_q.led_fn[9:0] == 10'h008) |-> raw_fn == (i_rx_pol_good && i_port_sel == PORT_TP))
        else $error("polarity term wrong");

    a_rx_only: assert property (
        (st_q.led_fn[9:0] == 10'h004) |-> raw_fn == i_rx_act)
        else $error("receive term wrong");

    a_rx_match_on: assert property (
        (st_q.led_fn[9:0] == 10'h024) |-> raw_fn == (i_rx_act && i_rx_addr_match))
        else $error("filtered receive term wrong");

    a_tx_only: assert property (
        (st_q.led_fn[9:0] == 10'h010) |-> raw_fn == i_tx_act)
        else $error("transmit term wrong");

    a_jab_only: assert property (
        (st_q.led_fn[9:0] == 10'h002) |-> raw_fn == i_jabber)
        else $error("jabber term wrong");

    a_coll_only: assert property (
        (st_q.led_fn[9:0] == 10'h001) |-> raw_fn == i_collision)
        else $error("collision term wrong");

    a_stretch_count: assert property (
        (st_q.led_fn[BIT_STRETCH] && !raw_fn && st_q.cnt != '0)
        |=> st_q.cnt == $past(st_q.cnt) - 1'b1)
        else $error("stretch counter did not count down");

    a_stretch_clear: assert property (
        (!st_q.led_fn[BIT_STRETCH]) |=> st_q.cnt == '0)
        else $error("stretch counter runs while disabled");

    a_misc_write: assert property (
        (i_write && st_q.bus == BUS_ACK && i_address == ADDR_MISC && i_byteenable[0])
        |=> o_full_duplex_enable == $past(i_writedata[BIT_FD_ENABLE])
        && o_attach_port_fd_enable == $past(i_writedata[BIT_ATTACH_FD]))
        else $error("duplex enable write lost");

    a_upper_zero: assert property (
        (i_read && st_q.bus == BUS_IDLE)
        |=> o_readdata[31:16] == 16'h0000 && !o_readdata[BIT_RSVD6])
        else $error("reserved read bits not zero");

    c_stretch_tail: cover property (
        st_q.led_fn[BIT_STRETCH] && $fell(raw_fn) ##1 !o_led_n);

    c_write_led: cover property (
        i_write && st_q.bus == BUS_ACK && i_address == ADDR_LED_FN);

    c_read_misc: cover property (
        i_read && st_q.bus == BUS_ACK && i_address == ADDR_MISC);

    c_stretch_restart: cover property (
        st_q.led_fn[BIT_STRETCH] && raw_fn && st_q.cnt != '0);

    c_fd_attach: cover property (
        st_q.led_fn[BIT_FD_LINK] && i_port_sel == PORT_AUI && fd_status);

endmodule : led_function_select

// [tb/led_indicator.sv]
`timescale 1ns/1ps

// ==========================================================
// Indicator LED on the pin; lit only while the pin is driven low
module led_indicator (
    // Pin from the block
    input wire logic i_led_n,
    // Observed light
    output logic o_lit
);
    // A floating or unknown pin never counts as lit
    assign o_lit = (i_led_n === 1'b0);
endmodule : led_indicator

// [tb/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
    import led_fn_pkg::*;
    localparam int SC = 8;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] i_address = 4'h0;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [3:0] i_byteenable = 4'hF;
    logic [31:0] o_readdata;
    logic o_waitrequest, o_full_duplex_enable, o_attach_port_fd_enable, o_led_n, lit;
    port_sel_t i_port_sel = PORT_TP;
    logic [7:0] ev = 8'h00;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #2 i_clk = ~i_clk;

    led_function_select #(.STRETCH_CYCLES(SC)) dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_port_sel(i_port_sel), .i_link_pass(ev[0]),
        .i_tx_act(ev[1]), .i_rx_act(ev[2]), .i_rx_addr_match(ev[3]),
        .i_rx_pol_good(ev[4]), .i_jabber(ev[5]), .i_collision(ev[6]),
        .i_magic_pkt(ev[7]), .o_full_duplex_enable(o_full_duplex_enable),
        .o_attach_port_fd_enable(o_attach_port_fd_enable), .o_led_n(o_led_n));

    led_indicator lamp (.i_led_n(o_led_n), .o_lit(lit));

    // ==========================================================
    // Checking and bus tasks
    task automatic report_and_stop;
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is seen low, released at that edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        @(posedge i_clk);
        i_read <= ~wr;
        i_write <= wr;
        i_address <= a;
        i_writedata <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (o_waitrequest === 1'b0) break;
        end
        if (n == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask : bus

    // Expected combined function; ev = magic,coll,jab,pol,match,rx,tx,link
    function automatic logic raw_fn(logic [15:0] en, logic [1:0] m, port_sel_t p,
                                    logic [7:0] e);
        logic fd;
        fd = (p == PORT_TP) ? (e[0] & m[0]) : (p == PORT_AUI) ? (m[0] & m[1]) :
             (p == PORT_GPSI) ? m[0] : 1'b0;
        return (en[8] & fd) | (en[4] & e[1]) | (en[2] & e[2] & (~en[5] | e[3])) |
               (en[3] & e[4] & (p == PORT_TP)) | (en[1] & e[5]) | (en[0] & e[6]) |
               (en[9] & e[7]);
    endfunction : raw_fn

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] rd;
        logic [15:0] en;
        logic [1:0] m;
        logic [7:0] e;
        logic r;
        port_sel_t p;
        int cnt, lo, hi;
        void'($urandom(32'h1ABE));
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b0, ADDR_LED_FN, 32'h0, rd);
        chk("led_reset", {16'h0, LED_FN_RESET}, rd);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, rd);
        bus(1'b0, 4'h8, 32'h0, rd);
        chk("unmapped_rd", 32'h0, rd);
        bus(1'b0, ADDR_MISC, 32'h0, rd);
        chk("misc_reset", 32'h0, rd);
        for (int i = 0; i < 64; i++) begin
            // Stretch kept off here so the pin tracks the function directly
            en = (i < 2) ? 16'hFF7F : 16'($urandom) & 16'hFF7F;
            m = (i < 2) ? 2'h3 : 2'($urandom);
            e = (i == 1) ? 8'hF7 : 8'($urandom);
            p = port_sel_t'($urandom_range(3, 0));
            bus(1'b1, ADDR_LED_FN, {16'h0, en}, rd);
            bus(1'b1, ADDR_MISC, {30'h0, m}, rd);
            @(posedge i_clk);
            ev <= e;
            i_port_sel <= p;
            r = raw_fn(en, m, p, e);
            bus(1'b0, ADDR_LED_FN, 32'h0, rd);
            chk("led_reg", {16'h0, r, 15'h0} | {16'h0, en & LED_FN_WMASK}, rd);
            @(negedge i_clk);
            chk("led_pin", {31'h0, ~r}, {31'h0, o_led_n});
            chk("led_lit", {31'h0, r}, {31'h0, lit});
            bus(1'b0, ADDR_MISC, 32'h0, rd);
            chk("misc_reg", {30'h0, m}, rd);
            chk("fd_out", {30'h0, m}, {30'h0, o_attach_port_fd_enable, o_full_duplex_enable});
        end
        // Stretcher: off, single pulse, and a second pulse restarting the hold
        for (int c = 0; c < 3; c++) begin
            @(posedge i_clk);
            ev <= 8'h00;
            bus(1'b1, ADDR_LED_FN, (c == 0) ? 32'h10 : 32'h90, rd);
            repeat (SC + 4) @(posedge i_clk);
            cnt = 0;
            for (int k = 0; k < 40; k++) begin
                @(posedge i_clk);
                ev <= (k == 0 || (c == 2 && k == 5)) ? 8'h02 : 8'h00;
                @(negedge i_clk);
                if (lit) cnt++;
            end
            lo = (c == 0) ? 1 : SC + 1 + ((c == 2) ? 5 : 0);
            hi = lo;
            chk("stretch_len", 32'h1, {31'h0, (cnt >= lo && cnt <= hi)});
        end
        report_and_stop();
    end
endmodule : tb_top
